// >>> hdl/sfb_map.svh
// constants for the serial flash bus slave
`ifndef SFB_MAP_SVH
`define SFB_MAP_SVH
`define SFB_OP_CAR_LEGACY 8'he8
`define SFB_OP_CAR        8'h0b
`define SFB_OP_CAR_LF     8'h03
`define SFB_OP_PAGE_RD    8'hd2
`define SFB_OP_BUF1_RD    8'hd4
`define SFB_OP_BUF2_RD    8'hd6
`define SFB_OP_BUF1_RD_LF 8'hd1
`define SFB_OP_BUF2_RD_LF 8'hd3
`define SFB_OP_PROT_RD    8'h32
`define SFB_OP_LOCK_RD    8'h35
`define SFB_OP_SEC_RD     8'h77
`define SFB_OP_STAT_RD    8'hd7
`define SFB_OP_ID_RD      8'h9f
`define SFB_ADDR_BYTES    3'h3
`define SFB_DUMMY_FAST    3'h1
`define SFB_DUMMY_LEGACY  3'h4
`endif

// >>> hdl/sfb_pkg.sv
// types for the serial flash bus slave
package sfb_pkg;
  typedef enum logic [3:0] {
    SFB_K_NONE, SFB_K_CAR, SFB_K_CAR_LF, SFB_K_PAGE, SFB_K_BUF1,
    SFB_K_BUF2, SFB_K_PROT, SFB_K_LOCK, SFB_K_SEC, SFB_K_STAT, SFB_K_ID
  } sfb_kind_e;
  typedef enum logic [1:0] {SFB_OPC, SFB_ADR, SFB_DUM, SFB_DAT} sfb_phase_e;
endpackage : sfb_pkg

// >>> hdl/sfb_slave.sv
// serial flash bus slave: command decode and read data shifter
`timescale 1ns/10ps
`include "sfb_map.svh"
module sfb_slave
  import sfb_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // serial pins
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe,
  // read data source
  output logic             rd_start,
  output logic [3:0]       rd_kind,
  output logic [23:0]      rd_addr,
  output logic             rd_next,
  input  wire logic [7:0]  rd_data
);
  typedef struct packed {
    logic [2:0]  cs_sy;
    logic [2:0]  sck_sy;
    logic [2:0]  si_sy;
    logic        cs_q;
    logic        sck_q;
    logic        si_q;
    sfb_phase_e  phase;
    sfb_kind_e   kind;
    logic [7:0]  sh_in;
    logic [2:0]  bitc;
    logic [2:0]  bytec;
    logic [23:0] addr;
    logic [7:0]  sh_out;
    logic        so;
    logic        so_oe;
    logic        rd_start;
    logic        rd_next;
    logic [2:0]  dum;
  } sfb_state_s;

  sfb_state_s st_r;
  sfb_state_s st_nxt;
  // kept apart from the state: only this pair sees the raw nrst
  logic [1:0] rst_sync_r;
  logic       rst_n;
  assign rst_n = rst_sync_r[1];

  function automatic sfb_kind_e decode(input logic [7:0] op);
    unique case (op)
      `SFB_OP_CAR, `SFB_OP_CAR_LEGACY:    decode = SFB_K_CAR;
      `SFB_OP_CAR_LF:                     decode = SFB_K_CAR_LF;
      `SFB_OP_PAGE_RD:                    decode = SFB_K_PAGE;
      `SFB_OP_BUF1_RD, `SFB_OP_BUF1_RD_LF: decode = SFB_K_BUF1;
      `SFB_OP_BUF2_RD, `SFB_OP_BUF2_RD_LF: decode = SFB_K_BUF2;
      `SFB_OP_PROT_RD:                    decode = SFB_K_PROT;
      `SFB_OP_LOCK_RD:                    decode = SFB_K_LOCK;
      `SFB_OP_SEC_RD:                     decode = SFB_K_SEC;
      `SFB_OP_STAT_RD:                    decode = SFB_K_STAT;
      `SFB_OP_ID_RD:                      decode = SFB_K_ID;
      default:                            decode = SFB_K_NONE;
    endcase
  endfunction : decode

  function automatic logic [2:0] dummies(input logic [7:0] op);
    unique case (op)
      `SFB_OP_CAR_LEGACY, `SFB_OP_PAGE_RD, `SFB_OP_SEC_RD:
        dummies = `SFB_DUMMY_LEGACY;
      `SFB_OP_CAR, `SFB_OP_BUF1_RD, `SFB_OP_BUF2_RD:
        dummies = `SFB_DUMMY_FAST;
      default: dummies = 3'h0;
    endcase
  endfunction : dummies

  always_comb begin
    logic       sck_rise;
    logic       sck_fall;
    logic [7:0] byte_in;
    logic [2:0] dcnt;
    st_nxt = st_r;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    byte_in = 8'h00;
    dcnt = 3'h0;
    st_nxt.cs_sy = {st_r.cs_sy[1:0], cs_n};
    st_nxt.sck_sy = {st_r.sck_sy[1:0], sck};
    st_nxt.si_sy = {st_r.si_sy[1:0], si};
    // a change counts once stages two and three agree
    if (st_r.cs_sy[1] == st_r.cs_sy[2]) st_nxt.cs_q = st_r.cs_sy[2];
    if (st_r.sck_sy[1] == st_r.sck_sy[2]) st_nxt.sck_q = st_r.sck_sy[2];
    if (st_r.si_sy[1] == st_r.si_sy[2]) st_nxt.si_q = st_r.si_sy[2];
    sck_rise = !st_r.cs_q && st_nxt.sck_q && !st_r.sck_q;
    sck_fall = !st_r.cs_q && !st_nxt.sck_q && st_r.sck_q;
    st_nxt.rd_start = 1'b0;
    st_nxt.rd_next = 1'b0;
    if (st_r.cs_q) begin
      // idle clock level is ignored, so mode 0 and 3 both work
      st_nxt.phase = SFB_OPC;
      st_nxt.bitc = 3'h0;
      st_nxt.bytec = 3'h0;
      st_nxt.so_oe = 1'b0;
      st_nxt.kind = SFB_K_NONE;
    end else if (sck_rise) begin
      byte_in = {st_r.sh_in[6:0], st_r.si_q};
      st_nxt.sh_in = byte_in;
      st_nxt.bitc = st_r.bitc + 3'h1;
      if (st_r.bitc == 3'h7) begin
        unique case (st_r.phase)
          SFB_OPC: begin
            st_nxt.kind = decode(byte_in);
            st_nxt.dum = dummies(byte_in);
            st_nxt.bytec = 3'h0;
            if (decode(byte_in) == SFB_K_STAT ||
                decode(byte_in) == SFB_K_ID) begin
              st_nxt.phase = SFB_DAT;
              st_nxt.rd_start = 1'b1;
            end else if (decode(byte_in) != SFB_K_NONE) begin
              st_nxt.phase = SFB_ADR;
            end else begin
              st_nxt.phase = SFB_DUM; // unknown opcode: stay silent
              st_nxt.dum = 3'h7;
            end
          end
          SFB_ADR: begin
            st_nxt.addr = {st_r.addr[15:0], byte_in};
            st_nxt.bytec = st_r.bytec + 3'h1;
            if (st_r.bytec == `SFB_ADDR_BYTES - 3'h1) begin
              st_nxt.bytec = 3'h0;
              if (st_r.dum == 3'h0) begin
                st_nxt.phase = SFB_DAT;
                st_nxt.rd_start = 1'b1;
              end else begin
                st_nxt.phase = SFB_DUM;
              end
            end
          end
          SFB_DUM: begin
            dcnt = st_r.bytec + 3'h1;
            st_nxt.bytec = dcnt;
            // unknown opcodes hold here with bytec wrapping
            if (dcnt == st_r.dum && st_r.kind != SFB_K_NONE) begin
              st_nxt.phase = SFB_DAT;
              st_nxt.rd_start = 1'b1;
            end
          end
          SFB_DAT: st_nxt.rd_next = 1'b1;
        endcase
      end
    end else if (sck_fall && st_r.phase == SFB_DAT) begin
      // launch at the falling edge: valid within clock_low_phase
      st_nxt.so_oe = 1'b1;
      if (st_r.bitc == 3'h0) begin
        st_nxt.so = rd_data[7];
        st_nxt.sh_out = {rd_data[6:0], 1'b0};
      end else begin
        st_nxt.so = st_r.sh_out[7];
        st_nxt.sh_out = {st_r.sh_out[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // state reset waits for the synchronised release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.cs_sy    <= 3'h7;
      st_r.sck_sy   <= 3'h0;
      st_r.si_sy    <= 3'h0;
      st_r.cs_q     <= 1'b1;
      st_r.sck_q    <= 1'b0;
      st_r.si_q     <= 1'b0;
      st_r.phase    <= SFB_OPC;
      st_r.kind     <= SFB_K_NONE;
      st_r.sh_in    <= 8'h00;
      st_r.bitc     <= 3'h0;
      st_r.bytec    <= 3'h0;
      st_r.addr     <= 24'h000000;
      st_r.sh_out   <= 8'h00;
      st_r.so       <= 1'b0;
      st_r.so_oe    <= 1'b0;
      st_r.rd_start <= 1'b0;
      st_r.rd_next  <= 1'b0;
      st_r.dum      <= 3'h0;
    end else begin
      st_r.cs_sy    <= st_nxt.cs_sy;
      st_r.sck_sy   <= st_nxt.sck_sy;
      st_r.si_sy    <= st_nxt.si_sy;
      st_r.cs_q     <= st_nxt.cs_q;
      st_r.sck_q    <= st_nxt.sck_q;
      st_r.si_q     <= st_nxt.si_q;
      st_r.phase    <= st_nxt.phase;
      st_r.kind     <= st_nxt.kind;
      st_r.sh_in    <= st_nxt.sh_in;
      st_r.bitc     <= st_nxt.bitc;
      st_r.bytec    <= st_nxt.bytec;
      st_r.addr     <= st_nxt.addr;
      st_r.sh_out   <= st_nxt.sh_out;
      st_r.so       <= st_nxt.so;
      st_r.so_oe    <= st_nxt.so_oe;
      st_r.rd_start <= st_nxt.rd_start;
      st_r.rd_next  <= st_nxt.rd_next;
      st_r.dum      <= st_nxt.dum;
    end
  end

  assign so       = st_r.so;
  assign so_oe    = st_r.so_oe;
  assign rd_start = st_r.rd_start;
  assign rd_kind  = st_r.kind;
  assign rd_addr  = st_r.addr;
  assign rd_next  = st_r.rd_next;
endmodule : sfb_slave

// >>> verification/sfb_host_model.sv
// host controller model, bus master of the serial flash bus
`timescale 1ns/10ps
module sfb_host_model (
  // clock
  input  wire logic core_clk,
  // serial pins
  input  wire logic so,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  logic samp[$];
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // samp[k] is so at the k-th falling edge
  task automatic frame(input logic [7:0] tx[$], input logic m3);
    logic q[$];
    foreach (tx[i]) for (int j = 7; j >= 0; j--) q.push_back(tx[i][j]);
    samp.delete();
    sck <= m3;
    si  <= q.pop_front();
    repeat (4) @(posedge core_clk);
    cs_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    // 200 ns period, low 5 and high 3 cycles: the slave's sync delay
    // must end inside the low phase
    for (int k = 0; ; k++) begin
      repeat (2) @(posedge core_clk);
      sck <= 1'b0;
      samp.push_back(so);
      if (k == 8 * tx.size()) break;
      repeat (5) @(posedge core_clk);
      sck <= 1'b1;
      @(posedge core_clk);
      si <= q.size() ? q.pop_front() : ~si;
    end
    si <= ~si;
    repeat (4) @(posedge core_clk);
    cs_n <= 1'b1;
    // idle level of the next frame is set at its own start
    repeat (8) @(posedge core_clk);
  endtask : frame
endmodule : sfb_host_model

// >>> verification/sfb_slave_assertions.sv
// port checks for the serial flash bus slave
`timescale 1ns/10ps
module sfb_slave_assertions (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // serial pins
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       so,
  input wire logic       so_oe,
  // read data source
  input wire logic       rd_start,
  input wire logic [3:0] rd_kind,
  input wire logic       rd_next
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_frame_end; $rose(cs_n); endsequence
  sequence s_oe_off; ##[1:6] !so_oe; endsequence
  AST_OE_ENDS: assert property (s_frame_end |-> s_oe_off)
    else $error("so_oe late after frame");
  AST_OE_IDLE: assert property (cs_n [*8] |-> !so_oe)
    else $error("so_oe outside frame");
  AST_SO_LOW: assert property (so_oe && $changed(so) |-> !sck)
    else $error("so moved in high phase");
  AST_OE_FALL: assert property ($rose(so_oe) |-> !cs_n && !sck)
    else $error("so_oe rose off a falling edge");
  AST_START_ONE: assert property (rd_start |=> !rd_start)
    else $error("rd_start too long");
  AST_NEXT_ONE: assert property (rd_next |=> !rd_next)
    else $error("rd_next too long");
  AST_NEXT_DRV: assert property (rd_next |-> so_oe && !cs_n)
    else $error("rd_next outside data");
  AST_KIND_SET: assert property ($changed(rd_kind) |->
    rd_kind == 4'h0 || $past(rd_kind) == 4'h0)
    else $error("rd_kind moved between two kinds");
  AST_START_OK: assert property (rd_start |-> !cs_n &&
    rd_kind != 4'h0 && rd_kind <= 4'ha)
    else $error("bad start");
endmodule : sfb_slave_assertions
bind sfb_slave sfb_slave_assertions sfb_slave_assertions_inst (
  .core_clk(core_clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .so(so),
  .so_oe(so_oe), .rd_start(rd_start), .rd_kind(rd_kind), .rd_next(rd_next));

// >>> verification/testbench.sv
// self-checking bench for the serial flash bus slave
`timescale 1ns/10ps
module testbench;
  logic        core_clk = 1'b0, nrst = 1'b0, cs_n, sck, si, so, so_oe;
  logic        rd_start, rd_next;
  logic [3:0]  rd_kind, got_k;
  logic [23:0] rd_addr, got_a;
  logic [7:0]  rd_data = 8'h00, nv, exp_q[$];
  int n_errors = 0, num_checks = 0, seed = 32'hfc08, n_cyc = 0, n_st = 0;
  int n_oe = 0, page_ptr = 0;
  // host-only write commands, not decoded by the slave; values arbitrary
  localparam logic [7:0] op_page_write   = 8'h5a;
  localparam logic [7:0] op_page_refresh = 8'h5b;
  // last entry is an unknown opcode, expected to be ignored
  logic [7:0] op_t[14] = '{8'he8, 8'h0b, 8'h03, 8'hd2, 8'hd4, 8'hd6, 8'hd1,
    8'hd3, 8'h32, 8'h35, 8'h77, 8'hd7, 8'h9f, 8'h55};
  int kd_t[14] = '{1, 1, 2, 3, 4, 5, 4, 5, 6, 7, 8, 9, 10, 0};
  int dm_t[14] = '{4, 1, 0, 4, 1, 1, 0, 0, 0, 0, 4, 0, 0, 0};
  always #12.5 core_clk = ~core_clk;
  // a released so line reads as the inverse of its last value
  sfb_host_model sfb_host_model_inst (.core_clk(core_clk),
    .so(so_oe ? so : ~so),
    .cs_n(cs_n), .sck(sck), .si(si));
  sfb_slave sfb_slave_inst (.core_clk(core_clk), .nrst(nrst), .cs_n(cs_n),
    .sck(sck), .si(si), .so(so), .so_oe(so_oe), .rd_start(rd_start),
    .rd_kind(rd_kind), .rd_addr(rd_addr), .rd_next(rd_next),
    .rd_data(rd_data));
  // data source: a fresh random byte per request, remembered in order
  always @(posedge core_clk) begin
    if (so_oe === 1'b1) n_oe++;
    if (rd_start === 1'b1 || rd_next === 1'b1) begin
      nv = 8'($random(seed));
      rd_data <= nv;
      exp_q.push_back(nv);
    end
    if (rd_start === 1'b1) begin
      n_st++;
      got_k <= rd_kind;
      got_a <= rd_addr;
    end
  end
  always @(posedge core_clk) if (++n_cyc == 20000) begin
    n_errors++;
    complete_run();
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic run_op(input int i);
    logic [23:0] a;
    logic [7:0]  tx[$], rxb;
    int          na, nb, n0, o0;
    a  = 24'($random(seed));
    na = (kd_t[i] >= 9) ? 0 : 3;
    tx = '{op_t[i]};
    for (int b = 0; b < na; b++) tx.push_back(a[23 - 8 * b -: 8]);
    for (int b = 0; b < dm_t[i]; b++) tx.push_back(8'($random(seed)));
    nb = tx.size();
    tx.push_back(8'h00);
    tx.push_back(8'hff);
    n0 = n_st;
    o0 = n_oe;
    exp_q.delete();
    sfb_host_model_inst.frame(tx, i[0]);
    chk(24'(n_st - n0), 24'(kd_t[i] != 0));
    if (kd_t[i] != 0) begin
      chk(24'(got_k), 24'(kd_t[i]));
      if (na != 0) chk(got_a, a);
      for (int b = 0; b < 2; b++) begin
        for (int j = 0; j < 8; j++)
          rxb = {rxb[6:0], sfb_host_model_inst.samp[8 * (nb + b) + j + 1]};
        chk(24'(rxb), 24'(exp_q[b]));
      end
    end else begin
      chk(24'(n_oe - o0), 24'h0);
    end
    $display("test opcode %h mode %0d done", op_t[i], 3 * i[0]);
  endtask : run_op
  // a write command must leave the slave silent
  task automatic wr_frame(input logic [7:0] op, input logic [23:0] a);
    logic [7:0] tx[$];
    int         n0, o0;
    tx = '{op, a[23:16], a[15:8], a[7:0], 8'($random(seed))};
    n0 = n_st;
    o0 = n_oe;
    sfb_host_model_inst.frame(tx, a[0]);
    chk(24'(n_st - n0), 24'h0);
    chk(24'(n_oe - o0), 24'h0);
    $display("test host write %h done", op);
  endtask : wr_frame
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (12) @(posedge core_clk);
    for (int i = 0; i < 14; i++) run_op(i);
    // each program is followed by a refresh at the page pointer
    for (int p = 0; p < 2; p++) begin
      wr_frame(op_page_write, 24'($random(seed)));
      wr_frame(op_page_refresh, 24'(page_ptr));
      page_ptr++;
    end
    complete_run();
  end
endmodule : testbench
